//--- src/expmul_pkg.sv
// shared constants and types for the exponent and multiply datapath
`default_nettype none
package expmul_pkg;
	localparam int WORD_W = 36;
	localparam int SC_W = 9;
	localparam int ADDR_W = 4;
	typedef logic [0:WORD_W-1] word_t;
	typedef logic [0:SC_W-1] count_t;
	// register indices on the plain port
	localparam logic [ADDR_W-1:0] IDX_ACC = 4'h0;
	localparam logic [ADDR_W-1:0] IDX_MEMBUF = 4'h1;
	localparam logic [ADDR_W-1:0] IDX_MULQ = 4'h2;
	localparam logic [ADDR_W-1:0] IDX_STEP = 4'h3;
	localparam logic [ADDR_W-1:0] IDX_EXPHOLD = 4'h4;
	localparam logic [ADDR_W-1:0] IDX_CTRL = 4'h5;
	localparam logic [ADDR_W-1:0] IDX_CMD = 4'h6;
	localparam logic [ADDR_W-1:0] IDX_STATUS = 4'h7;
	// field positions in the low end of a word
	localparam int CTRL_MODE_BIT = 35;
	localparam int CTRL_FIXRET_BIT = 34;
	localparam int CMD_EXP_BIT = 35;
	localparam int CMD_FIXMUL_BIT = 34;
	localparam int CMD_FLTMUL_BIT = 33;
	// step counter values
	localparam count_t SC_PRESET = 9'h080;
	localparam count_t SC_ALL_ONES = 9'h1FF;
	localparam count_t SC_RESET = 9'h000;
	localparam word_t WORD_RESET = 36'h0_0000_0000;
	localparam int FIXED_STEPS = 35;
	localparam int FLOAT_STEPS = 27;
	localparam int EXP_W = 8;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_EX_PRESET = 4'h1,
		ST_EX_SIGN = 4'h3,
		ST_EX_ADD1 = 4'h2,
		ST_EX_XOR = 4'h6,
		ST_EX_ADD2 = 4'h7,
		ST_EX_FINAL = 4'h5,
		ST_EX_STORE = 4'h4,
		ST_EX_RET = 4'hC,
		ST_M_SETUP = 4'hD,
		ST_M_DECIDE = 4'hF,
		ST_M_ARITH = 4'hE,
		ST_M_SHIFT = 4'hA,
		ST_M_FINISH = 4'hB,
		ST_M_RET = 4'h9
	} state_t;
endpackage : expmul_pkg
`default_nettype wire

//--- src/exponent_calc_and_multiply.sv
// exponent calculation and shift-and-add multiply subroutines with register port
//
// Implementation choices: the strobed register port and the register offsets.
`default_nettype none
module exponent_calc_and_multiply
	import expmul_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [0:WORD_W-1] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [0:WORD_W-1] rdata_out,
	output logic busy_out,
	output logic exponent_return_pulse_out,
	output logic multiply_return_pulse_out,
	output logic exp_overflow_out
);
	// word layout with bit 0 as sign, counter is nine bits
	typedef struct packed {
		state_t state;
		word_t accumulator_register;
		word_t memory_buffer;
		word_t multiplier_quotient;
		logic mq_extra;
		count_t step_counter;
		count_t exponent_holding;
		logic multiply_mode_flag;
		logic fixed_return_flag;
		logic busy;
		logic exp_ret;
		logic mul_ret;
		word_t rdata;
	} regs_t;

	regs_t cur_ff;
	regs_t nxt_ff;

	logic shift_fill;
	logic pair_equal;
	logic count_done;
	logic xor_signs;

	// float return flag is the mode flag itself
	assign shift_fill = (cur_ff.fixed_return_flag | cur_ff.multiply_mode_flag)
		? cur_ff.accumulator_register[0] : 1'b0;
	assign pair_equal = cur_ff.multiplier_quotient[35] == cur_ff.mq_extra;
	assign count_done = cur_ff.step_counter == SC_ALL_ONES;
	assign xor_signs = cur_ff.accumulator_register[0] ^ cur_ff.memory_buffer[0]
		^ cur_ff.multiply_mode_flag;

	always_comb begin
		nxt_ff = cur_ff;
		nxt_ff.exp_ret = 1'b0;
		nxt_ff.mul_ret = 1'b0;
		nxt_ff.rdata = WORD_RESET;
		if (rd_in) begin
			unique case (addr_in)
				IDX_ACC: nxt_ff.rdata = cur_ff.accumulator_register;
				IDX_MEMBUF: nxt_ff.rdata = cur_ff.memory_buffer;
				IDX_MULQ: nxt_ff.rdata = cur_ff.multiplier_quotient;
				IDX_STEP: nxt_ff.rdata[27:35] = cur_ff.step_counter;
				IDX_EXPHOLD: nxt_ff.rdata[27:35] = cur_ff.exponent_holding;
				IDX_CTRL: begin
					nxt_ff.rdata[CTRL_MODE_BIT] = cur_ff.multiply_mode_flag;
					nxt_ff.rdata[CTRL_FIXRET_BIT] = cur_ff.fixed_return_flag;
				end
				IDX_STATUS: begin
					nxt_ff.rdata[30:33] = cur_ff.state;
					nxt_ff.rdata[34] = cur_ff.mq_extra;
					nxt_ff.rdata[35] = cur_ff.busy;
				end
				default: nxt_ff.rdata = WORD_RESET;
			endcase
		end
		// operand loads are refused while a subroutine runs, so a sequence never sees a torn operand
		if (wr_in && !cur_ff.busy) begin
			unique case (addr_in)
				IDX_ACC: nxt_ff.accumulator_register = wdata_in;
				IDX_MEMBUF: nxt_ff.memory_buffer = wdata_in;
				IDX_MULQ: nxt_ff.multiplier_quotient = wdata_in;
				IDX_STEP: nxt_ff.step_counter = wdata_in[27:35];
				IDX_CTRL: begin
					nxt_ff.multiply_mode_flag = wdata_in[CTRL_MODE_BIT];
					nxt_ff.fixed_return_flag = wdata_in[CTRL_FIXRET_BIT];
				end
				IDX_CMD: begin
					if (wdata_in[CMD_EXP_BIT]) begin
						nxt_ff.state = ST_EX_PRESET;
						nxt_ff.busy = 1'b1;
					end else if (wdata_in[CMD_FIXMUL_BIT] || wdata_in[CMD_FLTMUL_BIT]) begin
						nxt_ff.state = ST_M_SETUP;
						nxt_ff.busy = 1'b1;
					end
				end
				default: ;
			endcase
		end
		unique case (cur_ff.state)
			ST_IDLE: ;
			ST_EX_PRESET: begin
				nxt_ff.step_counter = SC_PRESET;
				nxt_ff.state = ST_EX_SIGN;
			end
			ST_EX_SIGN: begin
				// the mode flag inverts the sign test, so divide reuses the multiply path
				if (cur_ff.accumulator_register[0] != cur_ff.multiply_mode_flag) begin
					nxt_ff.step_counter = ~cur_ff.step_counter;
				end
				nxt_ff.state = ST_EX_ADD1;
			end
			ST_EX_ADD1: begin
				// excess-128 field added with its sign
				nxt_ff.step_counter = cur_ff.step_counter + cur_ff.accumulator_register[0:8];
				nxt_ff.state = ST_EX_XOR;
			end
			ST_EX_XOR: begin
				if (!xor_signs) begin
					nxt_ff.step_counter = ~cur_ff.step_counter;
				end else begin
					nxt_ff.step_counter = cur_ff.step_counter + 9'h001;
				end
				nxt_ff.state = ST_EX_ADD2;
			end
			ST_EX_ADD2: begin
				nxt_ff.step_counter = cur_ff.step_counter + cur_ff.memory_buffer[0:8];
				nxt_ff.state = ST_EX_FINAL;
			end
			ST_EX_FINAL: begin
				if (cur_ff.memory_buffer[0] == cur_ff.multiply_mode_flag) begin
					nxt_ff.step_counter = ~cur_ff.step_counter;
				end
				nxt_ff.state = ST_EX_STORE;
			end
			ST_EX_STORE: begin
				// overflow stays visible in the sign for the normalize step
				nxt_ff.exponent_holding = cur_ff.step_counter;
				nxt_ff.step_counter = SC_RESET;
				nxt_ff.accumulator_register[1:EXP_W] = {EXP_W{cur_ff.accumulator_register[0]}};
				nxt_ff.memory_buffer[1:EXP_W] = {EXP_W{cur_ff.memory_buffer[0]}};
				nxt_ff.state = ST_EX_RET;
			end
			ST_EX_RET: begin
				nxt_ff.exp_ret = 1'b1;
				nxt_ff.busy = 1'b0;
				nxt_ff.state = ST_IDLE;
			end
			ST_M_SETUP: begin
				nxt_ff.multiplier_quotient = cur_ff.memory_buffer;
				nxt_ff.memory_buffer = cur_ff.accumulator_register;
				nxt_ff.accumulator_register = WORD_RESET;
				nxt_ff.mq_extra = 1'b0;
				nxt_ff.state = ST_M_DECIDE;
			end
			ST_M_DECIDE: begin
				// unequal pairs always do their arithmetic, even on the last step
				// otherwise the top transition into the sign would be lost
				if (!pair_equal) begin
					nxt_ff.state = ST_M_ARITH;
				end else if (count_done) begin
					nxt_ff.state = ST_M_FINISH;
				end else begin
					nxt_ff.state = ST_M_SHIFT;
				end
			end
			ST_M_ARITH: begin
				// pair 0-to-1 toward significance subtracts, 1-to-0 adds
				if (cur_ff.multiplier_quotient[35]) begin
					nxt_ff.accumulator_register = cur_ff.accumulator_register - cur_ff.memory_buffer;
				end else begin
					nxt_ff.accumulator_register = cur_ff.accumulator_register + cur_ff.memory_buffer;
				end
				nxt_ff.state = count_done ? ST_M_FINISH : ST_M_SHIFT;
			end
			ST_M_SHIFT: begin
				nxt_ff.step_counter = cur_ff.step_counter + 9'h001;
				// one chained shifter; low product bits enter as multiplier bits leave
				{nxt_ff.accumulator_register, nxt_ff.multiplier_quotient, nxt_ff.mq_extra} =
					{shift_fill, cur_ff.accumulator_register, cur_ff.multiplier_quotient};
				nxt_ff.state = ST_M_DECIDE;
			end
			ST_M_FINISH: begin
				// low half sits in bits 1-35 with accumulator sign in 0
				nxt_ff.step_counter = SC_RESET;
				nxt_ff.multiplier_quotient = {cur_ff.accumulator_register[0], cur_ff.multiplier_quotient[0:34]};
				nxt_ff.state = ST_M_RET;
			end
			ST_M_RET: begin
				nxt_ff.mul_ret = 1'b1;
				nxt_ff.busy = 1'b0;
				nxt_ff.state = ST_IDLE;
			end
			default: begin
				nxt_ff.busy = 1'b0;
				nxt_ff.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cur_ff <= '{state: ST_IDLE, accumulator_register: WORD_RESET, memory_buffer: WORD_RESET,
				multiplier_quotient: WORD_RESET, mq_extra: 1'b0, step_counter: SC_RESET,
				exponent_holding: SC_RESET, multiply_mode_flag: 1'b0, fixed_return_flag: 1'b0,
				busy: 1'b0, exp_ret: 1'b0, mul_ret: 1'b0, rdata: WORD_RESET};
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	assign rdata_out = cur_ff.rdata;
	assign busy_out = cur_ff.busy;
	assign exponent_return_pulse_out = cur_ff.exp_ret;
	assign multiply_return_pulse_out = cur_ff.mul_ret;
	assign exp_overflow_out = cur_ff.exponent_holding[0];

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	sequence s_ex_tail;
		cur_ff.state == ST_EX_RET ##1 exponent_return_pulse_out && !busy_out;
	endsequence

	sequence s_m_tail;
		cur_ff.step_counter == SC_RESET ##1 multiply_return_pulse_out && !busy_out;
	endsequence

	a_preset_value: assert property (cur_ff.state == ST_EX_PRESET |=>
		cur_ff.step_counter == 9'h080 && cur_ff.state == ST_EX_SIGN)
		else $error("counter not preset to 128");

	a_sign_compl: assert property (cur_ff.state == ST_EX_SIGN |=>
		cur_ff.step_counter == (($past(cur_ff.accumulator_register[0]) != cur_ff.multiply_mode_flag)
		? ~$past(cur_ff.step_counter) : $past(cur_ff.step_counter)))
		else $error("sign complement wrong");

	a_xor_adjust: assert property (cur_ff.state == ST_EX_XOR |=>
		cur_ff.step_counter == ($past(xor_signs) ? $past(cur_ff.step_counter) + 9'h001
		: ~$past(cur_ff.step_counter)))
		else $error("xor adjust wrong");

	a_final_compl: assert property (cur_ff.state == ST_EX_ADD2 |=> ##1
		cur_ff.step_counter == ((cur_ff.memory_buffer[0] == cur_ff.multiply_mode_flag)
		? ~$past(cur_ff.step_counter) : $past(cur_ff.step_counter)))
		else $error("final complement wrong");

	a_store_return: assert property (cur_ff.state == ST_EX_STORE |=>
		cur_ff.exponent_holding == $past(cur_ff.step_counter) && cur_ff.step_counter == SC_RESET
		&& cur_ff.accumulator_register[1:8] == {8{cur_ff.accumulator_register[0]}} ##0 s_ex_tail)
		else $error("exponent store or return wrong");

	a_setup_move: assert property (cur_ff.state == ST_M_SETUP |=>
		cur_ff.multiplier_quotient == $past(cur_ff.memory_buffer)
		&& cur_ff.memory_buffer == $past(cur_ff.accumulator_register)
		&& cur_ff.accumulator_register == WORD_RESET && !cur_ff.mq_extra)
		else $error("setup transfer wrong");

	a_shift_chain: assert property (cur_ff.state == ST_M_SHIFT |=>
		cur_ff.step_counter == $past(cur_ff.step_counter) + 9'h001
		&& cur_ff.mq_extra == $past(cur_ff.multiplier_quotient[35])
		&& cur_ff.multiplier_quotient[0] == $past(cur_ff.accumulator_register[35])
		&& cur_ff.state == ST_M_DECIDE)
		else $error("shift step wrong");

	a_pair_action: assert property (cur_ff.state == ST_M_ARITH && !cur_ff.multiplier_quotient[35] |=>
		cur_ff.accumulator_register == $past(cur_ff.accumulator_register) + $past(cur_ff.memory_buffer))
		else $error("add on 1-0 pair missing");

	a_exit_done: assert property (cur_ff.state == ST_M_DECIDE && pair_equal && count_done |=>
		cur_ff.state == ST_M_FINISH ##1 s_m_tail)
		else $error("loop did not exit on full count");

	a_finish_shift: assert property (cur_ff.state == ST_M_FINISH |=>
		cur_ff.multiplier_quotient[0] == cur_ff.accumulator_register[0]
		&& cur_ff.multiplier_quotient[1:35] == $past(cur_ff.multiplier_quotient[0:34]))
		else $error("final low half shift wrong");

	// step-level checks of the two subroutines

	a_acc_exp_add: assert property (cur_ff.state == ST_EX_ADD1 |=>
		cur_ff.step_counter == $past(cur_ff.step_counter) + $past(cur_ff.accumulator_register[0:8]))
		else $error("accumulator exponent add wrong");

	a_buf_exp_add: assert property (cur_ff.state == ST_EX_ADD2 |=>
		cur_ff.step_counter == $past(cur_ff.step_counter) + $past(cur_ff.memory_buffer[0:8]))
		else $error("buffer exponent add wrong");

	a_buf_sign_fill: assert property (cur_ff.state == ST_EX_STORE |=>
		cur_ff.memory_buffer[1:8] == {8{cur_ff.memory_buffer[0]}})
		else $error("buffer sign fill wrong");

	a_exp_order: assert property (cur_ff.state == ST_EX_SIGN |=>
		cur_ff.state == ST_EX_ADD1 ##1 cur_ff.state == ST_EX_XOR ##1 cur_ff.state == ST_EX_ADD2
		##1 cur_ff.state == ST_EX_FINAL ##1 cur_ff.state == ST_EX_STORE)
		else $error("exponent step order wrong");

	a_ovf_sign: assert property (cur_ff.state == ST_EX_STORE |=>
		exp_overflow_out == $past(cur_ff.step_counter[0]))
		else $error("overflow sign not kept");

	a_mode_steady: assert property (cur_ff.state != ST_IDLE |=>
		$stable(cur_ff.multiply_mode_flag))
		else $error("mode flag changed mid subroutine");

	a_exp_pulse_once: assert property (exponent_return_pulse_out |=>
		!exponent_return_pulse_out && !busy_out)
		else $error("exponent return pulse too long");

	a_busy_tracks: assert property (busy_out == (cur_ff.state != ST_IDLE))
		else $error("busy does not follow state");

	a_setup_entry: assert property (cur_ff.state == ST_M_SETUP |=>
		cur_ff.state == ST_M_DECIDE)
		else $error("setup did not enter decision");

	a_decide_uneq: assert property (cur_ff.state == ST_M_DECIDE && !pair_equal |=>
		cur_ff.state == ST_M_ARITH)
		else $error("unequal pair skipped arithmetic");

	a_equal_no_arith: assert property (cur_ff.state == ST_M_DECIDE && pair_equal && !count_done |=>
		cur_ff.state == ST_M_SHIFT && $stable(cur_ff.accumulator_register))
		else $error("equal pair touched accumulator");

	a_pair_subtract: assert property (cur_ff.state == ST_M_ARITH && cur_ff.multiplier_quotient[35] |=>
		cur_ff.accumulator_register == $past(cur_ff.accumulator_register) - $past(cur_ff.memory_buffer))
		else $error("subtract on 0-1 pair missing");

	a_arith_to_shift: assert property (cur_ff.state == ST_M_ARITH && !count_done |=>
		cur_ff.state == ST_M_SHIFT)
		else $error("arithmetic return did not shift");

	a_arith_exit: assert property (cur_ff.state == ST_M_ARITH && count_done |=>
		cur_ff.state == ST_M_FINISH)
		else $error("last arithmetic did not exit");

	a_shift_fill_sign: assert property (cur_ff.state == ST_M_SHIFT
		&& (cur_ff.fixed_return_flag || cur_ff.multiply_mode_flag) |=>
		cur_ff.accumulator_register[0] == $past(cur_ff.accumulator_register[0]))
		else $error("shift fill not sign");

	a_chain_low: assert property (cur_ff.state == ST_M_SHIFT |=>
		cur_ff.multiplier_quotient[1:35] == $past(cur_ff.multiplier_quotient[0:34])
		&& cur_ff.accumulator_register[1:35] == $past(cur_ff.accumulator_register[0:34]))
		else $error("chained shift wrong");

	a_mul_pulse_once: assert property (multiply_return_pulse_out |=>
		!multiply_return_pulse_out && !busy_out)
		else $error("multiply return pulse too long");

	// read data must not linger, or a stale word could pass as a fresh read
	a_read_one_cycle: assert property (!rd_in |=> rdata_out == WORD_RESET)
		else $error("read data stood too long");

endmodule : exponent_calc_and_multiply
`default_nettype wire

//--- bench/caller_model.sv
// calling-sequence model: drives the register port and waits for the return pulse
`default_nettype none
module caller_model
	import expmul_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic [0:WORD_W-1] rdata_in,
	input wire logic exp_ret_in,
	input wire logic mul_ret_in,
	output logic [ADDR_W-1:0] addr_out,
	output logic [0:WORD_W-1] wdata_out,
	output logic wr_out,
	output logic rd_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		addr_out = 4'h0;
		wdata_out = WORD_RESET;
		wr_out = 1'h0;
		rd_out = 1'h0;
	end
	// released lines show the inverse so a stale value is never mistaken for a live one
	task automatic wr_reg(input logic [ADDR_W-1:0] a, input word_t d);
		@(posedge ref_clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'h1;
		@(posedge ref_clk_in);
		wr_out <= 1'h0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask : wr_reg
	task automatic rd_reg(input logic [ADDR_W-1:0] a, output word_t d);
		@(posedge ref_clk_in);
		addr_out <= a;
		rd_out <= 1'h1;
		@(posedge ref_clk_in);
		rd_out <= 1'h0;
		addr_out <= ~a;
		@(negedge ref_clk_in);
		d = rdata_in;
	endtask : rd_reg
	task automatic wait_ret(input logic is_mul, output int n);
		n = 0;
		do begin
			@(negedge ref_clk_in);
			n++;
		end while ((is_mul ? mul_ret_in : exp_ret_in) !== 1'h1 && n < 400);
	endtask : wait_ret
	task automatic run_exp(input word_t a, input word_t b, input logic m, input logic junk, output int n);
		wr_reg(IDX_ACC, a);
		wr_reg(IDX_MEMBUF, b);
		wr_reg(IDX_CTRL, {35'h0, m});
		wr_reg(IDX_CMD, 36'h1);
		if (junk) begin
			wr_reg(IDX_ACC, ~a);
		end
		wait_ret(1'h0, n);
	endtask : run_exp
	task automatic run_mul(input word_t a, input word_t b, input logic flt, output int n);
		wr_reg(IDX_ACC, a);
		wr_reg(IDX_MEMBUF, b);
		wr_reg(IDX_STEP, {27'h0, flt ? ~9'h01B : ~9'h023});
		wr_reg(IDX_CTRL, flt ? 36'h1 : 36'h2);
		wr_reg(IDX_CMD, flt ? 36'h4 : 36'h2);
		wait_ret(1'h1, n);
	endtask : run_mul
endmodule : caller_model
`default_nettype wire

//--- bench/tb.sv
// self-checking bench for the exponent and multiply datapath
`default_nettype none
module tb;
	import expmul_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk, rst, wr, rd, busy, exp_ret, mul_ret, ovf;
	logic [ADDR_W-1:0] addr;
	word_t wdata, rdata;
	int err_total = 0;
	int compares = 0;
	int cycles = 0;
	// float operands carry their sign in bits 1-8, as the exponent step leaves them
	word_t ma [6] = '{36'h000000007, 36'hFFFFFFFFD, 36'h123456789, 36'h7FFFFFFFF, 36'h007F00FF0, 36'hFF8654321};
	word_t mb [6] = '{36'h000000005, 36'h0000000B6, 36'hFFFF0F00F, 36'h7FFFFFFFF, 36'h005A5A5A5, 36'hFF8123456};
	logic fl [6] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1};
	exponent_calc_and_multiply uut (.ref_clk_in(ref_clk), .rst_in(rst), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr), .rd_in(rd), .rdata_out(rdata), .busy_out(busy), .exponent_return_pulse_out(exp_ret),
		.multiply_return_pulse_out(mul_ret), .exp_overflow_out(ovf));
	caller_model cl (.ref_clk_in(ref_clk), .rdata_in(rdata), .exp_ret_in(exp_ret), .mul_ret_in(mul_ret),
		.addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
	always #25 ref_clk = ~ref_clk;
	task automatic chk(input word_t got, input word_t exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic give_verdict();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : give_verdict
	// whole run needs well under 2000 cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			give_verdict();
		end
	end
	initial begin
		word_t d, ea, eb, pa;
		logic signed [71:0] p;
		int n, st;
		logic s1, s2, m;
		logic [7:0] fa, fb;
		ref_clk = 1'h0;
		rst = 1'h1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'h0;
		for (int i = 0; i < 9; i++) begin
			cl.rd_reg(4'(i), d);
			chk(d, WORD_RESET);
		end
		$display("test reset_values done");
		// x = 5, y = -2 in excess-128; last case overflows
		for (int i = 0; i < 9; i++) begin
			m = (i < 4 || i == 8);
			s1 = i[0];
			s2 = i[1];
			fa = (i == 8) ? 8'hFF : 8'h85;
			fb = (i == 8) ? 8'hFF : 8'h7E;
			ea = {s1, s1 ? ~fa : fa, 27'h2A5A5A5};
			eb = {s2, s2 ? ~fb : fb, 27'h1234567};
			cl.run_exp(ea, eb, m, i == 0, n);
			chk(36'(n), (i == 0) ? 36'h7 : 36'h9);
			chk({35'h0, busy}, 36'h0);
			cl.rd_reg(IDX_EXPHOLD, d);
			chk(d, (i == 8) ? 36'h17E : (m ? 36'h083 : 36'h087));
			chk({35'h0, ovf}, (i == 8) ? 36'h1 : 36'h0);
			cl.rd_reg(IDX_ACC, d);
			chk(d, {s1, {8{s1}}, 27'h2A5A5A5});
			cl.rd_reg(IDX_MEMBUF, d);
			chk(d, {s2, {8{s2}}, 27'h1234567});
			cl.rd_reg(IDX_STEP, d);
			chk(d, WORD_RESET);
		end
		$display("test exponent done");
		for (int i = 0; i < 6; i++) begin
			st = fl[i] ? FLOAT_STEPS : FIXED_STEPS;
			cl.run_mul(ma[i], mb[i], fl[i], n);
			chk(36'(n < 400), 36'h1);
			p = $signed(ma[i]) * $signed(mb[i]);
			pa = p[st +: 36];
			cl.rd_reg(IDX_ACC, d);
			chk(d, pa);
			cl.rd_reg(IDX_MULQ, d);
			chk(d, fl[i] ? {pa[0], p[26:0], {8{mb[i][0]}}} : {pa[0], p[34:0]});
			cl.rd_reg(IDX_STEP, d);
			chk(d, WORD_RESET);
		end
		$display("test multiply done");
		give_verdict();
	end
endmodule : tb
`default_nettype wire
